// ==== io_rack_model.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// One fitted module in a rack; every other slot reads as empty.
module io_rack_model #(
  parameter logic [6:0] FIT_SLOT = 7'h03,
  parameter logic [7:0] FIT_TYPE = 8'h5a,
  parameter logic [6:0] FIT_POINTS = 7'h10
) (
  // Slot being probed.
  input wire logic [6:0] i_slot,
  // Module answer.
  output plc_map_pkg::probe_t o_probe
);
  wire fitted = (i_slot == FIT_SLOT);
  // Empty slots drive a pattern that moves with the slot, so stale values never match.
  assign o_probe.present = fitted;
  assign o_probe.type_code = fitted ? FIT_TYPE : ~{1'b0, i_slot};
  assign o_probe.points = fitted ? FIT_POINTS : ~i_slot;
endmodule

// ==== plc_indirect_address_map.sv ====
`timescale 1ns/10ps
module plc_indirect_address_map #(
  parameter int MS_CYCLES = plc_map_pkg::MS_CYCLES
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port.
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [15:0] o_rdata,
  // Address translation.
  input wire logic i_xlat_req,
  input wire plc_map_pkg::xlat_req_t i_xlat,
  input wire logic [1:0] i_exec_prog,
  output logic o_xlat_valid,
  output plc_map_pkg::xlat_res_t o_xlat,
  // Installed module probe.
  output logic [6:0] o_probe_slot,
  input wire plc_map_pkg::probe_t i_probe,
  // Execution events.
  input wire logic i_run,
  input wire logic i_scan_begin,
  input wire logic i_main_begin,
  input wire logic i_scan_end,
  input wire logic i_cmd_error,
  input wire logic i_data_error,
  // Execution control.
  output logic [2:0] o_prog_execute,
  output logic [2:0] o_prog_running,
  output logic o_stop,
  output logic o_verify_busy
);
  typedef enum logic [1:0] {V_IDLE, V_SCAN} verify_state_t;

  logic [15:0] ctrl;
  logic [3:0] policy;
  logic [15:0] scan_all;
  logic [15:0] scan_init;
  logic [15:0] scan_main;
  logic [11:0] link_cnt;
  logic [6:0] table_idx;
  logic [15:0] table_mem [128];
  logic [127:0] table_valid;
  logic [6:0] err;
  logic [15:0] pair_base [plc_map_pkg::PAIR_COUNT];
  verify_state_t vstate;
  logic mismatch_acc;
  logic [12:0] points_sum;
  logic [15:0] div_cnt;
  logic scan_active;
  logic in_main;
  logic [15:0] all_ms;
  logic [15:0] phase_ms;

  ////////////////////////////////////////////////////////////////////////////
  wire wr_ctrl = i_write && i_addr == plc_map_pkg::REG_CTRL;
  wire wr_link = i_write && i_addr == plc_map_pkg::REG_LINK_CNT;
  wire wr_table = i_write && i_addr == plc_map_pkg::REG_TABLE_DATA;
  wire wr_errors = i_write && i_addr == plc_map_pkg::REG_ERRORS;
  wire wr_pair = i_write && i_addr[4:3] == plc_map_pkg::REG_PAIR_BASE[4:3];
  wire [2:0] pair_sel = i_addr[2:0];
  wire [15:0] pair_partner = pair_base[{pair_sel[2:1], ~pair_sel[0]}];
  wire pair_clash = wr_pair && i_wdata == pair_partner;
  wire [1:0] mode = ctrl[plc_map_pkg::CTRL_MODE_LSB +: 2];
  wire [5:0] link_sum = {2'h0, i_wdata[3:0]} + {2'h0, i_wdata[7:4]} + {2'h0, i_wdata[11:8]};
  wire link_bad = link_sum > plc_map_pkg::LINK_MAX_TOTAL ||
    i_wdata[3:0] > plc_map_pkg::LINK_MAX_PROG || i_wdata[7:4] > plc_map_pkg::LINK_MAX_PROG ||
    i_wdata[11:8] > plc_map_pkg::LINK_MAX_PROG;
  wire [5:0] link_total = {2'h0, link_cnt[3:0]} + {2'h0, link_cnt[7:4]} +
    {2'h0, link_cnt[11:8]};
  // Every installed link module starts with an equal slice of the exchange memory.
  wire [15:0] link_share = link_total == 6'h00 ? 16'h0000 :
    16'(plc_map_pkg::LINK_MEM_BYTES / {10'h000, link_total});
  wire table_idx_ok = table_idx <= plc_map_pkg::SLOT_LAST;
  wire table_pts_ok = i_wdata[plc_map_pkg::ENT_PTS_LSB +: 7] <= plc_map_pkg::MAX_SLOT_POINTS;
  wire table_ok = table_idx_ok && table_pts_ok;
  wire [15:0] scan_wval = i_wdata == 16'h0000 ? plc_map_pkg::SCAN_MIN_MS : i_wdata;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl <= 16'h0000;
      policy <= 4'hf;
      scan_all <= 16'hffff;
      scan_init <= 16'hffff;
      scan_main <= 16'hffff;
      link_cnt <= 12'h000;
      table_idx <= 7'h00;
    end else if (i_write) begin
      case (i_addr)
        plc_map_pkg::REG_CTRL: ctrl <= i_wdata & ~(16'h0001 << plc_map_pkg::CTRL_VERIFY);
        plc_map_pkg::REG_POLICY: policy <= i_wdata[3:0];
        plc_map_pkg::REG_SCAN_ALL: scan_all <= scan_wval;
        plc_map_pkg::REG_SCAN_INIT: scan_init <= scan_wval;
        plc_map_pkg::REG_SCAN_MAIN: scan_main <= scan_wval;
        plc_map_pkg::REG_LINK_CNT: link_cnt <= link_bad ? link_cnt : i_wdata[11:0];
        plc_map_pkg::REG_TABLE_IDX: table_idx <= i_wdata[6:0];
        plc_map_pkg::REG_TABLE_DATA: table_idx <= table_idx + 7'h01;
        default: ;
      endcase
    end
  end

  // The table is plain memory; its valid bits alone carry reset state.
  always_ff @(posedge i_clk) begin
    if (wr_table && table_ok) begin
      table_mem[table_idx] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      table_valid <= '0;
    end else if (wr_table && table_ok) begin
      table_valid[table_idx] <= 1'b1;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < plc_map_pkg::PAIR_COUNT; gp++) begin : g_pair
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          pair_base[gp] <= 16'(gp) * plc_map_pkg::PAIR_RESET_STEP;
        end else if (wr_pair && !pair_clash && pair_sel == 3'(gp)) begin
          pair_base[gp] <= i_wdata;
        end
      end
      if (gp % 2 == 0) begin : g_chk
        pair_distinct_a: assert property (@(posedge i_clk) disable iff (i_reset)
          pair_base[gp] != pair_base[gp + 1]) else $error("paired bases coincide");
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  logic chk_mismatch;
  logic [6:0] chk_points;
  wire [15:0] cur_entry = table_mem[o_probe_slot];
  wire cur_valid = table_valid[o_probe_slot];
  wire verify_last = vstate == V_SCAN && o_probe_slot == plc_map_pkg::SLOT_LAST;
  wire verify_fail = verify_last && (mismatch_acc || chk_mismatch);

  slot_check u_slot_check (
    .i_entry(cur_entry),
    .i_valid(cur_valid),
    .i_probe(i_probe),
    .o_mismatch(chk_mismatch),
    .o_points(chk_points)
  );

  // Reset release starts a full sweep, as does a software request.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      vstate <= V_SCAN;
      o_probe_slot <= 7'h00;
      mismatch_acc <= 1'b0;
      points_sum <= 13'h0000;
    end else begin
      case (vstate)
        V_IDLE: begin
          if (wr_ctrl && i_wdata[plc_map_pkg::CTRL_VERIFY]) begin
            vstate <= V_SCAN;
            o_probe_slot <= 7'h00;
            mismatch_acc <= 1'b0;
            points_sum <= 13'h0000;
          end
        end
        V_SCAN: begin
          mismatch_acc <= mismatch_acc || chk_mismatch;
          points_sum <= points_sum + {6'h00, chk_points};
          o_probe_slot <= o_probe_slot + 7'h01;
          if (verify_last) begin
            vstate <= V_IDLE;
          end
        end
        default: vstate <= V_IDLE;
      endcase
    end
  end

  assign o_verify_busy = vstate == V_SCAN;

  verify_error_a: assert property (@(posedge i_clk) disable iff (i_reset)
    verify_fail |=> err[plc_map_pkg::ERR_IO] && !o_verify_busy)
    else $error("I/O table mismatch not flagged");

  points_pref_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_verify_busy && cur_valid && cur_entry[plc_map_pkg::ENT_PTS_SET] |->
    chk_points == cur_entry[plc_map_pkg::ENT_PTS_LSB +: 7]) else $error("points not preferred");

  ////////////////////////////////////////////////////////////////////////////
  wire ms_tick = div_cnt == 16'(MS_CYCLES - 1);
  wire [15:0] phase_limit = in_main ? scan_main : scan_init;
  wire scan_over = scan_active && (all_ms >= scan_all || phase_ms >= phase_limit);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= ms_tick ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  // One overrun is reported per scan; the timer then waits for the next scan.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scan_active <= 1'b0;
      in_main <= 1'b0;
      all_ms <= 16'h0000;
      phase_ms <= 16'h0000;
    end else if (i_scan_begin) begin
      scan_active <= 1'b1;
      in_main <= 1'b0;
      all_ms <= 16'h0000;
      phase_ms <= 16'h0000;
    end else begin
      if (i_scan_end || scan_over) begin
        scan_active <= 1'b0;
      end
      if (i_main_begin) begin
        in_main <= 1'b1;
        phase_ms <= 16'h0000;
      end else if (ms_tick && phase_ms != 16'hffff) begin
        phase_ms <= phase_ms + 16'h0001;
      end
      if (ms_tick && all_ms != 16'hffff) begin
        all_ms <= all_ms + 16'h0001;
      end
    end
  end

  scan_min_a: assert property (@(posedge i_clk) disable iff (i_reset)
    scan_all >= plc_map_pkg::SCAN_MIN_MS && scan_init >= plc_map_pkg::SCAN_MIN_MS &&
    scan_main >= plc_map_pkg::SCAN_MIN_MS) else $error("scan limit below one");

  ////////////////////////////////////////////////////////////////////////////
  wire [6:0] err_set = {wr_table && !table_ok, wr_link && link_bad, pair_clash,
    i_data_error, i_cmd_error, verify_fail, scan_over};
  wire [6:0] err_clr = wr_errors ? i_wdata[6:0] : 7'h00;

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      err <= 7'h00;
    end else begin
      err <= (err & ~err_clr) | err_set;
    end
  end

  assign o_stop = |(err[3:0] & policy);
  assign o_prog_execute = {ctrl[plc_map_pkg::CTRL_EN3], ctrl[plc_map_pkg::CTRL_EN2], 1'b1};
  assign o_prog_running[0] = !o_stop && i_run;
  assign o_prog_running[1] = !o_stop && o_prog_execute[1] &&
    (i_run || !ctrl[plc_map_pkg::CTRL_LINK2]);
  assign o_prog_running[2] = !o_stop && o_prog_execute[2] &&
    (i_run || !ctrl[plc_map_pkg::CTRL_LINK3]);

  stop_policy_a: assert property (@(posedge i_clk) disable iff (i_reset)
    scan_over && policy[plc_map_pkg::ERR_SCAN] |=> o_stop && o_prog_running == 3'h0)
    else $error("scan overrun did not stop");

  prog_one_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_prog_execute[0] && (o_prog_running[0] == (i_run && !o_stop)))
    else $error("program one not fixed");

  link_limit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_link && link_bad |=> $stable(link_cnt) && err[plc_map_pkg::REJ_LINK])
    else $error("link limit not enforced");

  ////////////////////////////////////////////////////////////////////////////
  wire [1:0] tgt_raw = i_xlat.value[15:plc_map_pkg::AREA_LSB];
  wire [1:0] tgt_area = i_xlat.direct ? i_exec_prog : tgt_raw;
  // A common data area folds every program target onto the first one.
  wire [1:0] map_area = (mode == plc_map_pkg::MODE_SINGLE && tgt_area != plc_map_pkg::AREA_EXT)
    ? plc_map_pkg::AREA_P1 : tgt_area;
  wire operand_bad = !i_xlat.direct && i_xlat.operand_area != tgt_raw;
  wire exec_bad = i_xlat.direct && i_exec_prog == plc_map_pkg::AREA_EXT;
  wire compat_bad = mode == plc_map_pkg::MODE_COMPAT && tgt_area != plc_map_pkg::AREA_P1;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_xlat_valid <= 1'b0;
      o_xlat <= '0;
    end else begin
      o_xlat_valid <= i_xlat_req;
      if (i_xlat_req) begin
        o_xlat.area <= map_area;
        o_xlat.word <= i_xlat.value[13:1];
        o_xlat.upper <= i_xlat.value[0];
        o_xlat.fault <= operand_bad || exec_bad || compat_bad;
      end
    end
  end

  area_select_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_xlat_req && !i_xlat.direct && mode == plc_map_pkg::MODE_SEPARATE |=>
    o_xlat_valid && o_xlat.area == $past(i_xlat.value[15:14])) else $error("wrong area");

  location_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_xlat_req |=> {o_xlat.word, o_xlat.upper} == $past(i_xlat.value[13:0]))
    else $error("wrong location");

  operand_area_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_xlat_req && !i_xlat.direct && i_xlat.operand_area != i_xlat.value[15:14] |=>
    o_xlat.fault) else $error("foreign operand accepted");

  p2_word0_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_xlat_req && !i_xlat.direct && i_xlat.value == plc_map_pkg::P2_WORD0_LOW &&
    i_xlat.operand_area == plc_map_pkg::AREA_P2 && mode == plc_map_pkg::MODE_SEPARATE |=>
    o_xlat.area == plc_map_pkg::AREA_P2 && o_xlat.word == plc_map_pkg::P2_WORD0_LOW[13:1] &&
    !o_xlat.upper && !o_xlat.fault) else $error("program two word zero missed");

  direct_area_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_xlat_req && i_xlat.direct && mode == plc_map_pkg::MODE_SEPARATE |=>
    o_xlat.area == $past(i_exec_prog)) else $error("direct not own area");

  ////////////////////////////////////////////////////////////////////////////
  wire [15:0] read_mux =
    i_addr == plc_map_pkg::REG_CTRL ? ctrl :
    i_addr == plc_map_pkg::REG_POLICY ? {12'h000, policy} :
    i_addr == plc_map_pkg::REG_SCAN_ALL ? scan_all :
    i_addr == plc_map_pkg::REG_SCAN_INIT ? scan_init :
    i_addr == plc_map_pkg::REG_SCAN_MAIN ? scan_main :
    i_addr == plc_map_pkg::REG_LINK_CNT ? {4'h0, link_cnt} :
    i_addr == plc_map_pkg::REG_TABLE_IDX ? {9'h000, table_idx} :
    i_addr == plc_map_pkg::REG_STATUS ? {12'h000, in_main, scan_active, o_stop, o_verify_busy} :
    i_addr == plc_map_pkg::REG_ERRORS ? {9'h000, err} :
    i_addr == plc_map_pkg::REG_LINK_SHARE ? link_share :
    i_addr == plc_map_pkg::REG_POINTS ? {3'h0, points_sum} :
    wr_pair || i_addr[4:3] == plc_map_pkg::REG_PAIR_BASE[4:3] ? pair_base[pair_sel] :
    16'h0000;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_read ? read_mux : 16'h0000;
    end
  end
endmodule

// ==== plc_indirect_address_map_tb.sv ====
`timescale 1ns/10ps
module plc_indirect_address_map_tb;
  logic i_clk, i_reset, i_write, i_read, i_xlat_req, i_run;
  logic i_scan_begin, i_main_begin, i_scan_end, i_cmd_error, i_data_error;
  logic [4:0] i_addr;
  logic [15:0] i_wdata, o_rdata;
  logic [1:0] i_exec_prog;
  plc_map_pkg::xlat_req_t i_xlat;
  plc_map_pkg::xlat_res_t o_xlat;
  plc_map_pkg::probe_t i_probe;
  logic o_xlat_valid, o_stop, o_verify_busy, rd_seen;
  logic [6:0] o_probe_slot;
  logic [2:0] o_prog_execute, o_prog_running;
  int failures, n_checks;
  logic [15:0] rq[$];
  plc_map_pkg::xlat_res_t xq[$];
  logic xfull[$];
  plc_indirect_address_map #(.MS_CYCLES(10)) uut (.i_clk(i_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .o_rdata(o_rdata), .i_xlat_req(i_xlat_req), .i_xlat(i_xlat), .i_exec_prog(i_exec_prog),
    .o_xlat_valid(o_xlat_valid), .o_xlat(o_xlat), .o_probe_slot(o_probe_slot),
    .i_probe(i_probe), .i_run(i_run), .i_scan_begin(i_scan_begin),
    .i_main_begin(i_main_begin), .i_scan_end(i_scan_end), .i_cmd_error(i_cmd_error),
    .i_data_error(i_data_error), .o_prog_execute(o_prog_execute),
    .o_prog_running(o_prog_running), .o_stop(o_stop), .o_verify_busy(o_verify_busy));
  io_rack_model rack (.i_slot(o_probe_slot), .o_probe(i_probe));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic complete_run;
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic note(input logic bad, input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (bad) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    note(got !== exp, 19'(got), 19'(exp));
  endtask
  task automatic cmp_xlat(input plc_map_pkg::xlat_res_t got, input plc_map_pkg::xlat_res_t exp,
                          input logic full);
    note(full ? (got !== exp) : (got.fault !== exp.fault), 19'(got), 19'(exp));
  endtask
  task automatic cmp_lvl(input logic [3:0] got, input logic [3:0] exp);
    note(got !== exp, 19'(got), 19'(exp));
  endtask
  // Scoreboard: read data stands only in the cycle after the strobe.
  always @(posedge i_clk) begin
    if (rd_seen) cmp16(o_rdata, rq.pop_front());
    if (o_xlat_valid && xq.size() > 0) cmp_xlat(o_xlat, xq.pop_front(), xfull.pop_front());
    else if (o_xlat_valid) failures++;
    rd_seen <= i_read;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clk);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge i_clk);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clk);
    i_read <= 1'b0;
  endtask
  task automatic xl(input logic dir, input logic [1:0] op, input logic [15:0] v,
                    input logic [1:0] ep, input logic [1:0] ea, input logic f, input logic full);
    xq.push_back(plc_map_pkg::xlat_res_t'{ea, v[13:1], v[0], f});
    xfull.push_back(full);
    @(posedge i_clk);
    i_xlat <= plc_map_pkg::xlat_req_t'{dir, op, v};
    i_exec_prog <= ep;
    i_xlat_req <= 1'b1;
    @(posedge i_clk);
    i_xlat_req <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  // The sweep lasts 120 cycles, so 300 is a generous bound.
  task automatic wait_sweep;
    int n;
    n = 0;
    settle();
    while (o_verify_busy !== 1'b0 && n < 300) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n >= 300) failures++;
  endtask
  initial begin
    #200000;
    failures++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic [1:0] p;
    {i_reset, i_write, i_read, i_xlat_req, i_run, i_scan_begin, i_main_begin} = 7'h40;
    {i_scan_end, i_cmd_error, i_data_error, i_addr, i_wdata, i_exec_prog, i_xlat} = '0;
    rd_seen = 1'b0;
    void'($urandom(30891));
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    wait_sweep();
    rd(plc_map_pkg::REG_ERRORS, 16'h0002);
    cmp_lvl({3'h0, o_stop}, 4'h1);
    rd(plc_map_pkg::REG_CTRL, 16'h0000);
    rd(plc_map_pkg::REG_POLICY, 16'h000f);
    rd(plc_map_pkg::REG_SCAN_INIT, 16'hffff);
    rd(plc_map_pkg::REG_LINK_SHARE, 16'h0000);
    for (int k = 0; k < 8; k++) rd(5'(plc_map_pkg::REG_PAIR_BASE + k), 16'(k * 256));
    rd(5'h1f, 16'h0000);
    wr(plc_map_pkg::REG_POLICY, 16'h0000);
    wr(plc_map_pkg::REG_ERRORS, 16'hffff);
    wr(5'(plc_map_pkg::REG_PAIR_BASE + 1), 16'h0000);
    rd(5'(plc_map_pkg::REG_PAIR_BASE + 1), 16'h0100);
    wr(plc_map_pkg::REG_LINK_CNT, 16'h0888);
    wr(plc_map_pkg::REG_LINK_CNT, 16'h0009);
    rd(plc_map_pkg::REG_LINK_CNT, 16'h0000);
    wr(plc_map_pkg::REG_LINK_CNT, 16'h0464);
    rd(plc_map_pkg::REG_LINK_CNT, 16'h0464);
    rd(plc_map_pkg::REG_LINK_SHARE, 16'h1124);
    rd(plc_map_pkg::REG_ERRORS, 16'h0030);
    wr(plc_map_pkg::REG_SCAN_ALL, 16'h0000);
    rd(plc_map_pkg::REG_SCAN_ALL, 16'h0001);
    // Configured 32 points must win over the 16 the module reports.
    wr(plc_map_pkg::REG_TABLE_IDX, 16'h0003);
    wr(plc_map_pkg::REG_TABLE_DATA, 16'ha05a);
    wr(plc_map_pkg::REG_TABLE_IDX, 16'h0077);
    wr(plc_map_pkg::REG_TABLE_DATA, 16'hc100);
    wr(plc_map_pkg::REG_TABLE_DATA, 16'h0000);
    rd(plc_map_pkg::REG_ERRORS, 16'h0070);
    wr(plc_map_pkg::REG_ERRORS, 16'hffff);
    wr(plc_map_pkg::REG_CTRL, 16'h0100);
    settle();
    cmp_lvl({3'h0, o_verify_busy}, 4'h1);
    wait_sweep();
    rd(plc_map_pkg::REG_ERRORS, 16'h0000);
    rd(plc_map_pkg::REG_POINTS, 16'h0020);
    cmp_lvl({1'b0, o_prog_execute}, 4'h1);
    wr(plc_map_pkg::REG_CTRL, 16'h0007);
    settle();
    cmp_lvl({1'b0, o_prog_execute}, 4'h7);
    cmp_lvl({1'b0, o_prog_running}, 4'h4);
    i_run <= 1'b1;
    settle();
    cmp_lvl({1'b0, o_prog_running}, 4'h7);
    for (int k = 0; k < 12; k++) begin
      v = 16'($urandom);
      p = 2'($urandom_range(3, 1));
      xl(1'b0, v[15:14], v, p, v[15:14], 1'b0, 1'b1);
      xl(1'b0, ~v[15:14], v, p, v[15:14], 1'b1, 1'b0);
      xl(1'b1, 2'($urandom), v, p, p, 1'b0, 1'b1);
    end
    xl(1'b0, 2'h2, plc_map_pkg::P2_WORD0_LOW, 2'h1, 2'h2, 1'b0, 1'b1);
    wr(plc_map_pkg::REG_CTRL, 16'h0017);
    xl(1'b0, 2'h3, 16'hc123, 2'h2, 2'h1, 1'b0, 1'b1);
    wr(plc_map_pkg::REG_CTRL, 16'h0027);
    xl(1'b0, 2'h2, 16'h8000, 2'h1, 2'h2, 1'b1, 1'b0);
    xl(1'b0, 2'h1, 16'h4003, 2'h1, 2'h1, 1'b0, 1'b1);
    wr(plc_map_pkg::REG_SCAN_ALL, 16'h0002);
    wr(plc_map_pkg::REG_POLICY, 16'h0001);
    @(posedge i_clk) i_scan_begin <= 1'b1;
    @(posedge i_clk) i_scan_begin <= 1'b0;
    @(posedge i_clk) i_main_begin <= 1'b1;
    @(posedge i_clk) i_main_begin <= 1'b0;
    repeat (50) @(posedge i_clk);
    i_cmd_error <= 1'b1;
    @(posedge i_clk) i_cmd_error <= 1'b0;
    @(posedge i_clk) i_data_error <= 1'b1;
    @(posedge i_clk) i_data_error <= 1'b0;
    @(posedge i_clk) i_scan_end <= 1'b1;
    @(posedge i_clk) i_scan_end <= 1'b0;
    rd(plc_map_pkg::REG_ERRORS, 16'h000d);
    cmp_lvl({3'h0, o_stop}, 4'h1);
    cmp_lvl({1'b0, o_prog_running}, 4'h0);
    wr(plc_map_pkg::REG_POLICY, 16'h0000);
    settle();
    cmp_lvl({3'h0, o_stop}, 4'h0);
    wr(plc_map_pkg::REG_POLICY, 16'h0004);
    settle();
    cmp_lvl({3'h0, o_stop}, 4'h1);
    settle();
    complete_run();
  end
endmodule

// ==== plc_map_pkg.sv ====
package plc_map_pkg;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_POLICY = 5'h01;
  localparam logic [4:0] REG_SCAN_ALL = 5'h02;
  localparam logic [4:0] REG_SCAN_INIT = 5'h03;
  localparam logic [4:0] REG_SCAN_MAIN = 5'h04;
  localparam logic [4:0] REG_LINK_CNT = 5'h05;
  localparam logic [4:0] REG_TABLE_IDX = 5'h06;
  localparam logic [4:0] REG_TABLE_DATA = 5'h07;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_ERRORS = 5'h09;
  localparam logic [4:0] REG_LINK_SHARE = 5'h0a;
  localparam logic [4:0] REG_POINTS = 5'h0b;
  localparam logic [4:0] REG_PAIR_BASE = 5'h10;
  localparam int CTRL_EN2 = 0;
  localparam int CTRL_EN3 = 1;
  localparam int CTRL_LINK2 = 2;
  localparam int CTRL_LINK3 = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_VERIFY = 8;
  localparam logic [1:0] MODE_SEPARATE = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_COMPAT = 2'h2;
  localparam logic [15:0] OFS_EXT = 16'h0000;
  localparam logic [15:0] OFS_P1 = 16'h4000;
  localparam logic [15:0] OFS_P2 = 16'h8000;
  localparam logic [15:0] OFS_P3 = 16'hc000;
  localparam logic [15:0] P2_WORD0_LOW = 16'ha000;
  localparam int AREA_LSB = 14;
  localparam logic [1:0] AREA_EXT = OFS_EXT[15:14];
  localparam logic [1:0] AREA_P1 = OFS_P1[15:14];
  localparam logic [1:0] AREA_P2 = OFS_P2[15:14];
  localparam logic [1:0] AREA_P3 = OFS_P3[15:14];
  localparam int ENT_PTS_LSB = 8;
  localparam int ENT_PTS_SET = 15;
  localparam logic [6:0] MAX_SLOT_POINTS = 7'h40;
  localparam int SLOTS_PER_RACK = 8;
  localparam int RACKS = 15;
  localparam logic [6:0] SLOT_LAST = 7'(RACKS * SLOTS_PER_RACK - 1);
  localparam logic [5:0] LINK_MAX_TOTAL = 6'h0e;
  localparam logic [3:0] LINK_MAX_PROG = 4'h8;
  localparam int LINK_MEM_KBYTES = 60;
  localparam int KBYTE = 1024;
  localparam logic [15:0] LINK_MEM_BYTES = 16'(LINK_MEM_KBYTES * KBYTE);
  localparam logic [15:0] SCAN_MIN_MS = 16'h0001;
  localparam int CLK_HZ = 50000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int ERR_SCAN = 0;
  localparam int ERR_IO = 1;
  localparam int ERR_CMD = 2;
  localparam int ERR_DATA = 3;
  localparam int REJ_PAIR = 4;
  localparam int REJ_LINK = 5;
  localparam int REJ_TABLE = 6;
  localparam int PAIR_COUNT = 8;
  localparam logic [15:0] PAIR_RESET_STEP = 16'h0100;
  typedef struct packed {
    logic direct;
    logic [1:0] operand_area;
    logic [15:0] value;
  } xlat_req_t;
  typedef struct packed {
    logic [1:0] area;
    logic [12:0] word;
    logic upper;
    logic fault;
  } xlat_res_t;
  typedef struct packed {
    logic present;
    logic [7:0] type_code;
    logic [6:0] points;
  } probe_t;
endpackage

// ==== slot_check.sv ====
`timescale 1ns/10ps
module slot_check (
  // Configured entry.
  input wire logic [15:0] i_entry,
  input wire logic i_valid,
  // Installed module.
  input wire plc_map_pkg::probe_t i_probe,
  // Result.
  output logic o_mismatch,
  output logic [6:0] o_points
);
  wire type_ok = i_entry[7:0] == i_probe.type_code;
  // A configured slot without a module, or a module without a setting, both fail.
  assign o_mismatch = (i_valid != i_probe.present) || (i_valid && !type_ok);
  // An empty slot adds no points unless its entry sets a count, whatever its probe lines happen to show.
  assign o_points = (i_valid && i_entry[plc_map_pkg::ENT_PTS_SET]) ?
    i_entry[plc_map_pkg::ENT_PTS_LSB +: 7] :
    (i_probe.present ? i_probe.points : 7'h00);
endmodule
